// ### ttc_consts.svh
`ifndef TTC_CONSTS_SVH
`define TTC_CONSTS_SVH
// Function
// - On-demand bit forces throttling immediately
// - On-demand duty taken from control bits 3:1
// - Duty from one to seven eighths on
// - Automatic throttling fixed at half on
// - Automatic duty overrides on-demand when hot
// - Hot indicator asserted at trip point
// - Snooping and interrupt latching continue while throttled
// - Hot indicator interrupt on chosen edges
// - No new hot assertion in stop-grant
// - Held hot stays until exit and cool
// - Catastrophic temperature shuts down, asserts trip
// - Trip independent of activity, no bus cycle
// - Per-core reading as offset below maximum
// - Reading valid only in normal state
// - Reading at maximum triggers automatic throttling
// - Sustained heat latches out-of-spec, sticky, interrupt
// - Two thresholds raise interrupts when crossed
// - External low on hot pin throttles
// - Any core trip drives shared hot pin
// - Throttle by stopping and starting core clocks
// - Automatic throttling ends with hysteresis

// Register byte offsets
`define TTC_OFF_CTRL    4'h0
`define TTC_OFF_STATUS  4'h4
`define TTC_OFF_THRESH  4'h8
`define TTC_OFF_TEMP    4'hc

// Control register width and register reset values
`define TTC_CTRL_W      10
`define TTC_CTRL_RST    10'h000
`define TTC_THRESH_RST  16'h0000

// Status bit positions
`define TTC_ST_HOT      0
`define TTC_ST_HOTASN   1
`define TTC_ST_HOTDEA   2
`define TTC_ST_OOS      3
`define TTC_ST_OOSLOG   4
`define TTC_ST_THR0     5
`define TTC_ST_THR1     6
`define TTC_ST_THROT    7
`define TTC_ST_TRIP     8
`define TTC_ST_EXTHOT   9

// Timing and thermal constants
`define TTC_CLK_MHZ     100
`define TTC_OOS_TIME_US 100
`define TTC_OOS_CYCLES  (`TTC_OOS_TIME_US * `TTC_CLK_MHZ)
`define TTC_STEP_CYCLES 16
`define TTC_AUTO_DUTY   3'h4
`define TTC_HYST_DEG    7'h02
`define TTC_TEMP_W      7
`define TTC_OE_HOLD     4
`endif

// ### ttc_pkg.sv
package ttc_pkg;
	// Control register layout, bit 0 at the bottom
	typedef struct packed {
		logic [1:0] thrIe;
		logic       oosIe;
		logic [1:0] hotEdge;
		logic       onDemand;
		logic [2:0] duty;
		logic       autoEn;
	} ttc_ctrl_t;

	// Source of the active throttle duty
	typedef enum logic [1:0] {
		TTC_THR_OFF,
		TTC_THR_DEMAND,
		TTC_THR_AUTO
	} ttc_mode_t;
endpackage

// ### ttc_duty_gate.sv
`include "ttc_consts.svh"
// Core clock gate: period of eight slices, duty slices on
module ttc_duty_gate #(
	parameter int STEP_CYCLES = `TTC_STEP_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       enable,
	input  wire logic [2:0] duty,
	output logic            gateOn_q
);
	localparam int SW = (STEP_CYCLES > 1) ? $clog2(STEP_CYCLES) : 1;
	localparam logic [SW-1:0] STEP_LAST = SW'(STEP_CYCLES - 1);

	logic [SW-1:0] sub_q;
	logic [SW-1:0] sub_d;
	logic [2:0]    slice_q;
	logic [2:0]    slice_d;
	logic [2:0]    dutyHeld_q;
	logic [2:0]    dutyHeld_d;
	logic          gateOn_d;
	logic          run_q;
	wire           subWrap = (sub_q == STEP_LAST);
	wire           periodEnd = subWrap && (slice_q == 3'h7);

	// Duty is latched per period so a rewrite never splits one
	assign sub_d      = (!enable || subWrap) ? '0 : sub_q + SW'(1);
	assign slice_d    = !enable ? 3'h0 : (subWrap ? slice_q + 3'h1 : slice_q);
	// First enabled cycle takes the live duty, never a stale idle value
	assign dutyHeld_d = (!enable || !run_q || periodEnd) ? duty : dutyHeld_q;
	// Clock stops for the slices past the duty, then restarts
	assign gateOn_d   = !enable || (slice_d < dutyHeld_d);

	// Counters and gate flop
	always_ff @(posedge clk) begin
		if (srst) begin
			sub_q      <= '0;
			slice_q    <= 3'h0;
			dutyHeld_q <= 3'h0;
			gateOn_q   <= 1'b1;
			run_q      <= 1'b0;
		end else begin
			run_q      <= enable;
			sub_q      <= sub_d;
			slice_q    <= slice_d;
			dutyHeld_q <= dutyHeld_d;
			gateOn_q   <= gateOn_d;
		end
	end
endmodule

// ### ttc_thermal_throttle.sv
`include "ttc_consts.svh"
// Thermal throttle control with Avalon-MM register slave
module ttc_thermal_throttle #(
	parameter int NUM_CORES   = 2,
	parameter int OOS_CYCLES  = `TTC_OOS_CYCLES,
	parameter int STEP_CYCLES = `TTC_STEP_CYCLES
) (
	input  wire logic                            clk,
	input  wire logic                            srst,
	input  wire logic [3:0]                      avsAddress,
	input  wire logic                            avsRead,
	input  wire logic                            avsWrite,
	input  wire logic [31:0]                     avsWritedata,
	input  wire logic [3:0]                      avsByteenable,
	output logic      [31:0]                     avsReaddata,
	output logic                                 avsWaitrequest,
	input  wire logic [NUM_CORES*`TTC_TEMP_W-1:0] coreTempOffset,
	input  wire logic                            pkgNormalState,
	input  wire logic                            stopGrant,
	input  wire logic                            catTempHigh,
	input  wire logic                            hotPinIn,
	output logic                                 hotPinOut,
	output logic                                 hotPinOe,
	output logic                                 catastrophicTripN,
	output logic                                 coreShutdown,
	output logic                                 coreClkEn,
	input  wire logic                            irqIn,
	input  wire logic                            irqAck,
	output logic                                 irqPending,
	output logic      [NUM_CORES-1:0]            thermalIrq
);
	localparam int TW = `TTC_TEMP_W;
	localparam int OW = $clog2(OOS_CYCLES + 1);
	localparam logic [OW-1:0] OOS_LAST = OW'(OOS_CYCLES);

	// ---------------- Register bus slave ----------------
	ttc_pkg::ttc_ctrl_t ctrl_q;
	ttc_pkg::ttc_ctrl_t ctrl_d;
	logic [15:0]        thresh_q;
	logic [15:0]        thresh_d;
	logic [31:0]        rdData_q;
	logic [31:0]        rdData_d;
	logic               wait_q;
	logic               wait_d;

	wire        busReq    = avsRead || avsWrite;
	wire        wrCommit  = avsWrite && !wait_q;
	wire        rdCapture = avsRead && wait_q;
	wire        selCtrl   = (avsAddress == `TTC_OFF_CTRL);
	wire        selStatus = (avsAddress == `TTC_OFF_STATUS);
	wire        selThresh = (avsAddress == `TTC_OFF_THRESH);
	wire        selTemp   = (avsAddress == `TTC_OFF_TEMP);
	wire [31:0] beMask    = {{8{avsByteenable[3]}}, {8{avsByteenable[2]}},
	                         {8{avsByteenable[1]}}, {8{avsByteenable[0]}}};
	wire [31:0] wrBits    = avsWritedata & beMask;
	wire [31:0] ctrlWord  = {22'h000000, ctrl_q};
	wire [31:0] ctrlMerge = (ctrlWord & ~beMask) | wrBits;
	wire [31:0] thrMerge  = ({16'h0000, thresh_q} & ~beMask) | wrBits;

	// One wait cycle per request, released at the accepting edge
	assign wait_d = !(busReq && wait_q);
	assign ctrl_d = (wrCommit && selCtrl) ?
		ttc_pkg::ttc_ctrl_t'(ctrlMerge[`TTC_CTRL_W-1:0]) : ctrl_q;
	assign thresh_d = (wrCommit && selThresh) ? thrMerge[15:0] : thresh_q;
	wire   clrStatus = wrCommit && selStatus;
	wire [31:0] clrBits = clrStatus ? wrBits : 32'h00000000;

	// Software-visible control and thresholds
	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_q   <= ttc_pkg::ttc_ctrl_t'(`TTC_CTRL_RST);
			thresh_q <= `TTC_THRESH_RST;
		end else begin
			ctrl_q   <= ctrl_d;
			thresh_q <= thresh_d;
		end
	end

	// Handshake state and captured read word
	always_ff @(posedge clk) begin
		if (srst) begin
			wait_q   <= 1'b1;
			rdData_q <= 32'h00000000;
		end else begin
			wait_q   <= wait_d;
			rdData_q <= rdData_d;
		end
	end

	// ---------------- Pin synchronisers ----------------
	logic [2:0] catSync_q;
	logic [2:0] hotSync_q;
	logic       hotLow_q;
	logic       hotLowPrev_q;

	// Three stages; a change counts once stages two and three agree
	always_ff @(posedge clk) begin
		if (srst) begin
			catSync_q <= 3'b000;
			hotSync_q <= 3'b111;
		end else begin
			catSync_q <= {catSync_q[1:0], catTempHigh};
			hotSync_q <= {hotSync_q[1:0], hotPinIn};
		end
	end
	wire catAgree  = catSync_q[1] && catSync_q[2];
	wire hotAgreeL = !hotSync_q[1] && !hotSync_q[2];
	wire hotAgreeH = hotSync_q[1] && hotSync_q[2];
	wire hotLow_d  = hotAgreeL ? 1'b1 : (hotAgreeH ? 1'b0 : hotLow_q);

	// ---------------- Per-core sensor readout ----------------
	logic [NUM_CORES-1:0] atMax;
	logic [NUM_CORES-1:0] belowHyst;
	logic [NUM_CORES-1:0] thr0Above_q;
	logic [NUM_CORES-1:0] thr1Above_q;
	logic [NUM_CORES-1:0] thr0Cross;
	logic [NUM_CORES-1:0] thr1Cross;
	logic [31:0]          tempWord;

	// Offset counts down to maximum, so it can never read above it
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CORES; gi++) begin : gCore
			wire [TW-1:0] offs = coreTempOffset[gi*TW +: TW];
			wire a0 = offs <= thresh_q[TW-1:0];
			wire a1 = offs <= thresh_q[8 +: TW];
			assign atMax[gi]     = (offs == '0);
			assign belowHyst[gi] = (offs < `TTC_HYST_DEG);
			// Crossings only count while the reading is meaningful
			assign thr0Cross[gi] = pkgNormalState && (a0 != thr0Above_q[gi]);
			assign thr1Cross[gi] = pkgNormalState && (a1 != thr1Above_q[gi]);
			if (gi < 4) begin : gWord
				assign tempWord[gi*8 +: 8] = {pkgNormalState, offs};
			end
			always_ff @(posedge clk) begin
				if (srst) begin
					thr0Above_q[gi] <= 1'b0;
					thr1Above_q[gi] <= 1'b0;
				end else if (pkgNormalState) begin
					thr0Above_q[gi] <= a0;
					thr1Above_q[gi] <= a1;
				end
			end
		end
		if (NUM_CORES < 4) begin : gPad
			assign tempWord[31:NUM_CORES*8] = '0;
		end
	endgenerate

	// ---------------- Trip point with hysteresis ----------------
	logic tripped_q;
	logic tripped_d;
	logic hotDrive_q;
	logic hotDrive_d;
	logic [`TTC_OE_HOLD-1:0] oeHist_q;

	// Low-power states hold the last judgement; reading not valid there
	assign tripped_d = !pkgNormalState ? tripped_q :
		((|atMax) || (tripped_q && (|belowHyst)));
	// In stop-grant the pin only keeps what it already had
	assign hotDrive_d = stopGrant ? hotDrive_q : tripped_q;
	// Own drive echoes back through the synchroniser; mask it meanwhile
	wire ownEcho = hotDrive_q || (|oeHist_q);
	wire extHot  = hotLow_q && !ownEcho;

	// ---------------- Mode selection ----------------
	ttc_pkg::ttc_mode_t mode;
	wire        autoHot  = ctrl_q.autoEn && (tripped_q || extHot);
	wire        demandOk = ctrl_q.onDemand && (ctrl_q.duty != 3'h0);
	// Automatic wins over on-demand whenever it is hot
	assign mode = autoHot ? ttc_pkg::TTC_THR_AUTO :
		(demandOk ? ttc_pkg::TTC_THR_DEMAND : ttc_pkg::TTC_THR_OFF);
	wire [2:0]  dutySel = (mode == ttc_pkg::TTC_THR_AUTO) ?
		`TTC_AUTO_DUTY : ctrl_q.duty;
	wire        throttling = (mode != ttc_pkg::TTC_THR_OFF);

	logic gateOn;
	ttc_duty_gate #(
		.STEP_CYCLES (STEP_CYCLES)
	) uGate (
		.clk      (clk),
		.srst     (srst),
		.enable   (throttling),
		.duty     (dutySel),
		.gateOn_q (gateOn)
	);

	// ---------------- Catastrophic trip ----------------
	logic catTrip_q;
	// Pure hardware path: no mode, no software and no bus involvement
	wire catTrip_d = catTrip_q || catAgree;

	// ---------------- Out-of-spec detection ----------------
	logic [OW-1:0] oosCnt_q;
	logic [OW-1:0] oosCnt_d;
	logic          oos_q;
	wire           hotHeld = ctrl_q.autoEn && tripped_q;
	assign oosCnt_d = !hotHeld ? '0 :
		((oosCnt_q == OOS_LAST) ? oosCnt_q : oosCnt_q + OW'(1));
	wire oos_d   = hotHeld && (oosCnt_d == OOS_LAST);
	wire oosRise = oos_d && !oos_q;

	// ---------------- Sticky status ----------------
	logic hotAsnLog_q;
	logic hotDeaLog_q;
	logic oosLog_q;
	logic thr0Log_q;
	logic thr1Log_q;
	wire  hotAsnEv = hotLow_d && !hotLowPrev_q;
	wire  hotDeaEv = !hotLow_d && hotLowPrev_q;
	// Set beats a simultaneous clear so no event is lost
	wire hotAsnLog_d = hotAsnEv || (hotAsnLog_q && !clrBits[`TTC_ST_HOTASN]);
	wire hotDeaLog_d = hotDeaEv || (hotDeaLog_q && !clrBits[`TTC_ST_HOTDEA]);
	wire oosLog_d    = oosRise || (oosLog_q && !clrBits[`TTC_ST_OOSLOG]);
	wire thr0Log_d   = (|thr0Cross) || (thr0Log_q && !clrBits[`TTC_ST_THR0]);
	wire thr1Log_d   = (|thr1Cross) || (thr1Log_q && !clrBits[`TTC_ST_THR1]);

	wire [31:0] statusWord = {22'h000000, extHot, catTrip_q, throttling,
		thr1Log_q, thr0Log_q, oosLog_q, oos_q, hotDeaLog_q, hotAsnLog_q, hotLow_q};

	// Unmapped offsets read as zero but still complete normally
	assign rdData_d = !rdCapture ? rdData_q :
		selCtrl   ? ctrlWord :
		selStatus ? statusWord :
		selThresh ? {16'h0000, thresh_q} :
		selTemp   ? tempWord : 32'h00000000;

	// ---------------- Interrupt requests ----------------
	// Edge choice: 01 assert, 10 deassert, 11 both, 00 none
	wire hotEdgeIrq = (ctrl_q.hotEdge[0] && hotAsnEv) ||
		(ctrl_q.hotEdge[1] && hotDeaEv);
	wire oosIrq = ctrl_q.oosIe && oosRise;
	logic [NUM_CORES-1:0] thermalIrq_d;
	// Each core's local controller hears its own threshold crossings
	assign thermalIrq_d = ({NUM_CORES{ctrl_q.thrIe[0]}} & thr0Cross) |
		({NUM_CORES{ctrl_q.thrIe[1]}} & thr1Cross) |
		{NUM_CORES{hotEdgeIrq || oosIrq}};

	// Incoming requests latch even with the core clock stopped
	wire irqPending_d = irqIn || (irqPending && !(irqAck && gateOn));

	// ---------------- State flops ----------------
	// Filtered pin level and its previous value for edge events
	always_ff @(posedge clk) begin
		if (srst) begin
			hotLow_q     <= 1'b0;
			hotLowPrev_q <= 1'b0;
		end else begin
			hotLow_q     <= hotLow_d;
			hotLowPrev_q <= hotLow_d;
		end
	end

	// Trip judgement, pin drive and the echo mask history
	always_ff @(posedge clk) begin
		if (srst) begin
			tripped_q  <= 1'b0;
			hotDrive_q <= 1'b0;
			oeHist_q   <= '0;
		end else begin
			tripped_q  <= tripped_d;
			hotDrive_q <= hotDrive_d;
			oeHist_q   <= {oeHist_q[`TTC_OE_HOLD-2:0], hotDrive_q};
		end
	end

	// Catastrophic latch; only reset releases it
	always_ff @(posedge clk) begin
		if (srst) begin
			catTrip_q <= 1'b0;
		end else begin
			catTrip_q <= catTrip_d;
		end
	end

	// Sustained-heat counter and out-of-spec level
	always_ff @(posedge clk) begin
		if (srst) begin
			oosCnt_q <= '0;
			oos_q    <= 1'b0;
		end else begin
			oosCnt_q <= oosCnt_d;
			oos_q    <= oos_d;
		end
	end

	// Sticky pin edge logs
	always_ff @(posedge clk) begin
		if (srst) begin
			hotAsnLog_q <= 1'b0;
			hotDeaLog_q <= 1'b0;
		end else begin
			hotAsnLog_q <= hotAsnLog_d;
			hotDeaLog_q <= hotDeaLog_d;
		end
	end

	// Sticky out-of-spec and threshold logs
	always_ff @(posedge clk) begin
		if (srst) begin
			oosLog_q  <= 1'b0;
			thr0Log_q <= 1'b0;
			thr1Log_q <= 1'b0;
		end else begin
			oosLog_q  <= oosLog_d;
			thr0Log_q <= thr0Log_d;
			thr1Log_q <= thr1Log_d;
		end
	end

	// ---------------- Registered outputs ----------------
	// Bus answer straight from flops
	always_ff @(posedge clk) begin
		if (srst) begin
			avsReaddata    <= 32'h00000000;
			avsWaitrequest <= 1'b1;
		end else begin
			avsReaddata    <= rdData_d;
			avsWaitrequest <= wait_d;
		end
	end

	// Open-drain: only ever drives low, enable marks the drive
	always_ff @(posedge clk) begin
		if (srst) begin
			hotPinOut         <= 1'b0;
			hotPinOe          <= 1'b0;
			catastrophicTripN <= 1'b1;
			coreShutdown      <= 1'b0;
		end else begin
			hotPinOut         <= 1'b0;
			hotPinOe          <= hotDrive_d;
			catastrophicTripN <= !catTrip_d;
			coreShutdown      <= catTrip_d;
		end
	end

	// Core side: a trip stops the clocks whatever the gate says
	always_ff @(posedge clk) begin
		if (srst) begin
			coreClkEn  <= 1'b1;
			irqPending <= 1'b0;
			thermalIrq <= '0;
		end else begin
			coreClkEn  <= gateOn && !catTrip_d;
			irqPending <= irqPending_d;
			thermalIrq <= thermalIrq_d;
		end
	end
endmodule

// ### ttc_thermal_throttle_assertions.sv
`include "ttc_consts.svh"
// Port-level checks of the throttle block
module ttc_thermal_throttle_checker #(
	parameter int NUM_CORES   = 2,
	parameter int STEP_CYCLES = `TTC_STEP_CYCLES
) (
	input wire logic                              clk,
	input wire logic                              srst,
	input wire logic                              avsRead,
	input wire logic                              avsWrite,
	input wire logic                              avsWaitrequest,
	input wire logic [NUM_CORES*`TTC_TEMP_W-1:0] coreTempOffset,
	input wire logic                              pkgNormalState,
	input wire logic                              stopGrant,
	input wire logic                              catTempHigh,
	input wire logic                              hotPinOe,
	input wire logic                              catastrophicTripN,
	input wire logic                              coreShutdown,
	input wire logic                              coreClkEn,
	input wire logic                              irqIn,
	input wire logic                              irqAck,
	input wire logic                              irqPending
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	logic       tripAny;
	logic [7:0] offCnt_q;
	// Any core at zero offset while readings are valid
	always_comb begin
		tripAny = 1'b0;
		for (int i = 0; i < NUM_CORES; i++) begin
			if (coreTempOffset[i*`TTC_TEMP_W +: `TTC_TEMP_W] == 7'h00) begin
				tripAny = pkgNormalState;
			end
		end
	end
	// Length of the current clock-off stretch, saturating
	always_ff @(posedge clk) begin
		if (srst || coreClkEn) offCnt_q <= 8'h00;
		else if (offCnt_q != 8'hff) offCnt_q <= offCnt_q + 8'h01;
	end
	a_wait_answer: assert property ((avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest)
		else $error("request not answered in the next cycle");
	a_wait_single: assert property (!avsWaitrequest |=> avsWaitrequest)
		else $error("waitrequest low for more than one cycle");
	a_trip_latch: assert property (!catastrophicTripN |=> !catastrophicTripN)
		else $error("trip output released without reset");
	a_trip_off: assert property (!catastrophicTripN |-> coreShutdown)
		else $error("trip without core shutdown");
	a_trip_rise: assert property ($rose(catTempHigh) |-> ##[1:8] !catastrophicTripN)
		else $error("trip output late");
	a_hot_drive: assert property ((!stopGrant && tripAny) [*4] |-> hotPinOe)
		else $error("hot pin not driven on trip");
	a_sg_no_new: assert property (stopGrant && $past(stopGrant) && $past(stopGrant, 2)
		&& $past(stopGrant, 3) && !$past(hotPinOe) |-> !hotPinOe)
		else $error("hot pin newly driven in stop-grant");
	a_sg_hold: assert property (stopGrant && $past(stopGrant) && hotPinOe |=> hotPinOe)
		else $error("hot pin dropped in stop-grant");
	a_clk_off_max: assert property (offCnt_q <= 7 * STEP_CYCLES || !catastrophicTripN)
		else $error("core clock off longer than seven slices");
	a_irq_latch: assert property (irqIn && !irqAck |=> irqPending)
		else $error("interrupt request not latched");
endmodule

bind ttc_thermal_throttle ttc_thermal_throttle_checker #(
	.NUM_CORES  (NUM_CORES),
	.STEP_CYCLES(STEP_CYCLES)
) u_chk (.clk, .srst, .avsRead, .avsWrite, .avsWaitrequest, .coreTempOffset, .pkgNormalState,
	.stopGrant, .catTempHigh, .hotPinOe, .catastrophicTripN, .coreShutdown, .coreClkEn,
	.irqIn, .irqAck, .irqPending);

// ### ttc_thermal_partner.sv
// Regulator monitor on the hot pin and platform power sequencer
module ttc_thermal_partner #(
	parameter int SUPPLY_DLY = 5
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic vrHot,
	input wire logic hotPinOut,
	input wire logic hotPinOe,
	input wire logic catastrophicTripN,
	output logic     hotPinWire,
	output logic     supplyOn
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] dlyCnt_q;
	// Pulled-up wire: low while either party pulls it
	assign hotPinWire = !((hotPinOe && !hotPinOut) || vrHot);
	// Supply cut a fixed delay after trip, back only on reset
	always_ff @(posedge clk) begin
		if (srst || catastrophicTripN) dlyCnt_q <= 8'h00;
		else if (dlyCnt_q < 8'(SUPPLY_DLY)) dlyCnt_q <= dlyCnt_q + 8'h01;
	end
	assign supplyOn = dlyCnt_q < 8'(SUPPLY_DLY);
endmodule

// ### ttc_thermal_throttle_tb_top.sv
module ttc_thermal_throttle_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int STEP = 2;
	logic        clk, srst, avsRead, avsWrite, pkgNormalState, stopGrant, catTempHigh;
	logic        irqIn, irqAck, vrHot, avsWaitrequest, hotPinIn, hotPinOut, hotPinOe;
	logic        catastrophicTripN, coreShutdown, coreClkEn, irqPending, supplyOn;
	logic [3:0]  avsAddress, avsByteenable;
	logic [31:0] avsWritedata, avsReaddata, rdv, v;
	logic [1:0]  thermalIrq, irqSeen;
	logic [13:0] coreTempOffset;
	int          error_cnt, num_checks, cyc, irqCnt, base;

	ttc_thermal_throttle #(.NUM_CORES(2), .OOS_CYCLES(20), .STEP_CYCLES(STEP)) u_dut (
		.clk, .srst, .avsAddress, .avsRead, .avsWrite, .avsWritedata, .avsByteenable,
		.avsReaddata, .avsWaitrequest, .coreTempOffset, .pkgNormalState, .stopGrant,
		.catTempHigh, .hotPinIn, .hotPinOut, .hotPinOe, .catastrophicTripN, .coreShutdown,
		.coreClkEn, .irqIn, .irqAck, .irqPending, .thermalIrq);
	ttc_thermal_partner #(.SUPPLY_DLY(5)) u_partner (.clk, .srst, .vrHot, .hotPinOut,
		.hotPinOe, .catastrophicTripN, .hotPinWire(hotPinIn), .supplyOn);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Watchdog; interrupt pulses are counted, being one cycle wide
	always @(posedge clk) begin
		cyc++;
		if (thermalIrq != 2'b00) irqCnt++;
		irqSeen = irqSeen | thermalIrq;
		if (cyc == 20000) begin
			error_cnt++;
			wrap_up();
		end
	end

	task chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	// One bus cycle held until waitrequest is sampled low
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		avsWrite <= w;
		avsRead <= !w;
		avsAddress <= a;
		avsWritedata <= d;
		do @(posedge clk); while (avsWaitrequest !== 1'b0);
		rdv = avsReaddata;
		avsWrite <= 1'b0;
		avsRead <= 1'b0;
		@(posedge clk);
	endtask
	// Settle past a period boundary, then count on-cycles over one period
	task gate(output logic [31:0] n);
		n = 32'h0;
		repeat (40) @(posedge clk);
		repeat (8 * STEP) begin
			@(posedge clk);
			n = n + coreClkEn;
		end
	endtask
	task t_regs();
		bus(1, 4'h2, 32'hffffffff);
		bus(0, 4'h2, 32'h0);
		chk(rdv, 32'h0);
		bus(0, 4'h0, 32'h0);
		chk(rdv, 32'h0);
	endtask
	task t_demand();
		for (int n = 0; n < 8; n++) begin
			bus(1, 4'h0, 32'h10 | 32'(n) << 1);
			bus(0, 4'h0, 32'h0);
			chk(rdv, 32'h10 | 32'(n) << 1);
			gate(v);
			chk(v, 32'(n == 0 ? 8 * STEP : n * STEP));
			bus(0, 4'h4, 32'h0);
			chk(rdv[7], n != 0);
		end
	endtask
	task t_auto();
		bus(1, 4'h0, 32'h93);
		base = irqCnt;
		coreTempOffset <= {7'h00, 7'h0a};
		gate(v);
		chk(v, 32'(4 * STEP));
		chk({hotPinOe, hotPinOut}, 2'b10);
		bus(0, 4'h4, 32'h0);
		chk(rdv & 32'h99, 32'h99);
		chk(irqCnt > base, 1'b1);
		coreTempOffset <= {7'h01, 7'h0a};
		gate(v);
		chk(hotPinOe, 1'b1);
		coreTempOffset <= {7'h02, 7'h0a};
		gate(v);
		chk(v, 32'(STEP));
		chk(hotPinOe, 1'b0);
		bus(0, 4'h4, 32'h0);
		chk(rdv & 32'h18, 32'h10);
		bus(1, 4'h4, 32'h10);
		bus(0, 4'h4, 32'h0);
		chk(rdv & 32'h18, 32'h0);
	endtask
	task t_ext();
		bus(1, 4'h0, 32'h21);
		bus(1, 4'h4, 32'h16);
		base = irqCnt;
		vrHot <= 1'b1;
		gate(v);
		chk(v, 32'(4 * STEP));
		bus(0, 4'h4, 32'h0);
		chk(rdv & 32'h206, 32'h202);
		chk(irqCnt > base, 1'b1);
		bus(1, 4'h0, 32'h41);
		base = irqCnt;
		vrHot <= 1'b0;
		gate(v);
		chk(v, 32'(8 * STEP));
		chk(irqCnt > base, 1'b1);
		base = irqCnt;
		vrHot <= 1'b1;
		gate(v);
		chk(irqCnt == base, 1'b1);
		bus(1, 4'h0, 32'h61);
		base = irqCnt;
		vrHot <= 1'b0;
		gate(v);
		chk(irqCnt == base + 1, 1'b1);
	endtask
	task t_sg();
		stopGrant <= 1'b1;
		coreTempOffset <= {7'h0a, 7'h00};
		repeat (20) @(posedge clk);
		chk(hotPinOe, 1'b0);
		stopGrant <= 1'b0;
		repeat (20) @(posedge clk);
		chk(hotPinOe, 1'b1);
		stopGrant <= 1'b1;
		coreTempOffset <= {7'h0a, 7'h0a};
		repeat (20) @(posedge clk);
		chk(hotPinOe, 1'b1);
		stopGrant <= 1'b0;
		repeat (20) @(posedge clk);
		chk(hotPinOe, 1'b0);
	endtask
	task t_dts();
		coreTempOffset <= {7'h15, 7'h2a};
		repeat (2) @(posedge clk);
		bus(0, 4'hc, 32'h0);
		chk(rdv, 32'h000095aa);
		pkgNormalState <= 1'b0;
		repeat (2) @(posedge clk);
		bus(0, 4'hc, 32'h0);
		chk(rdv, 32'h0000152a);
		pkgNormalState <= 1'b1;
	endtask
	task t_thr();
		bus(1, 4'h8, 32'h0510);
		bus(0, 4'h8, 32'h0);
		chk(rdv, 32'h0510);
		bus(1, 4'h0, 32'h300);
		bus(1, 4'h4, 32'h60);
		base = irqCnt;
		irqSeen = 2'b00;
		coreTempOffset <= {7'h15, 7'h04};
		repeat (10) @(posedge clk);
		bus(0, 4'h4, 32'h0);
		chk(rdv & 32'h60, 32'h60);
		chk(irqCnt > base, 1'b1);
		chk(irqSeen, 2'b01);
	endtask
	// Request arrives while the gate is mostly off
	task t_irq();
		bus(1, 4'h0, 32'h12);
		irqIn <= 1'b1;
		@(posedge clk);
		irqIn <= 1'b0;
		repeat (3) @(posedge clk);
		chk(irqPending, 1'b1);
		irqAck <= 1'b1;
		repeat (8 * STEP) @(posedge clk);
		irqAck <= 1'b0;
		@(posedge clk);
		chk(irqPending, 1'b0);
	endtask
	// Trip is last: only a reset clears it
	task t_trip();
		catTempHigh <= 1'b1;
		repeat (10) @(posedge clk);
		catTempHigh <= 1'b0;
		repeat (20) @(posedge clk);
		chk({catastrophicTripN, coreShutdown, supplyOn}, 3'b010);
		chk(avsWaitrequest, 1'b1);
		srst <= 1'b1;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		chk({catastrophicTripN, supplyOn}, 2'b11);
	endtask
	task wrap_up();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	initial begin
		{srst, pkgNormalState} = 2'b11;
		{avsRead, avsWrite, irqIn, irqAck, vrHot, stopGrant, catTempHigh} = 7'h00;
		{avsAddress, avsWritedata, avsByteenable} = {4'h0, 32'h0, 4'hf};
		coreTempOffset = {7'h0a, 7'h0a};
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		t_regs();
		t_demand();
		t_auto();
		t_ext();
		t_sg();
		t_dts();
		t_thr();
		t_irq();
		t_trip();
		wrap_up();
	end
endmodule
